// ### rtl/tpg_pkg.sv
// Package: register offsets, widths and reset values of the three-port GPIO block
package tpg_pkg;
    localparam int TPG_ADDR_W = 5;               // Register address width
    localparam int TPG_DATA_W = 8;               // Register data width
    localparam int TPG_PA_W = 8;                 // First port width
    localparam int TPG_PB_W = 4;                 // Second port width
    localparam int TPG_PC_W = 6;                 // Third port width
    // Register offsets
    localparam logic [4:0] TPG_OFS_A_IN = 5'h00;
    localparam logic [4:0] TPG_OFS_A_DIR = 5'h01;
    localparam logic [4:0] TPG_OFS_A_OUT = 5'h02;
    localparam logic [4:0] TPG_OFS_A_PUE = 5'h03;
    localparam logic [4:0] TPG_OFS_B_IN = 5'h04;
    localparam logic [4:0] TPG_OFS_B_DIR = 5'h05;
    localparam logic [4:0] TPG_OFS_B_OUT = 5'h06;
    localparam logic [4:0] TPG_OFS_B_PUE = 5'h07;
    localparam logic [4:0] TPG_OFS_CTRL = 5'h08;
    localparam logic [4:0] TPG_OFS_C_IN = 5'h1B;
    localparam logic [4:0] TPG_OFS_C_DIR = 5'h1C;
    localparam logic [4:0] TPG_OFS_C_OUT = 5'h1D;
    localparam logic [4:0] TPG_OFS_C_PUE = 5'h1E;
    // Control register fields
    localparam int TPG_CTRL_GAP_A = 0;
    localparam int TPG_CTRL_GAP_B = 1;
    localparam int TPG_CTRL_GAP_C = 2;
    localparam int TPG_CTRL_RSVD = 3;
    localparam logic [7:0] TPG_CTRL_WMASK = 8'hF7;  // Writable control bits
    localparam logic [7:0] TPG_RST_VAL = 8'h00;     // Reset value of every register
    localparam int TPG_GAP_CYCLES = 1;              // Tri-state gap length in cycles
endpackage : tpg_pkg

// ### rtl/tpg_port_if.sv
// Interface: one port's configuration travelling from register file to pin slice
interface tpg_port_if #(parameter int W = 8);
    logic [W-1:0] dir;        // Direction, 1 = output
    logic [W-1:0] latch;      // Output latch
    logic [W-1:0] pue;        // Pull-up enable
    logic gap_en;             // Break-before-make enable
    logic [W-1:0] dir_wr;     // Direction write pulse with new value
    logic dir_we;             // Direction write strobe
    logic [W-1:0] pin_oe_n;   // Pin output enable, low drives
    modport regs (output dir, latch, pue, gap_en, dir_wr, dir_we, input pin_oe_n);
    modport pins (input dir, latch, pue, gap_en, dir_wr, dir_we, output pin_oe_n);
endinterface : tpg_port_if

// ### rtl/tpg_pin_slice.sv
// Pin slice: break-before-make gap on direction changes to output
module tpg_pin_slice
    import tpg_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    tpg_port_if.pins port
);
    logic [W-1:0] gap_reg;     // Pins held tri-state this cycle
    logic [W-1:0] gap_next;
    logic [W-1:0] rising_out;  // Pins a direction write turns into outputs
    // A pin that becomes an output gets one gap cycle when enabled
    assign rising_out = port.dir_wr & ~port.dir;
    assign gap_next = (port.dir_we && port.gap_en) ? rising_out : '0;
    // Gap register clears itself after one cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            gap_reg <= '0;
        end else if (ce) begin
            gap_reg <= gap_next;
        end
    end
    // Driver enabled only for output pins outside their gap
    assign port.pin_oe_n = ~(port.dir & ~gap_reg);

    gap_one_a: assert property (@(posedge clock) disable iff (srst)
        (ce && port.dir_we && port.gap_en && |rising_out)
        |=> (gap_reg == $past(rising_out)))
        else $error("gap not raised after output switch");
    gap_end_a: assert property (@(posedge clock) disable iff (srst)
        (ce && gap_reg != '0 && !port.dir_we) |=> (gap_reg == '0))
        else $error("gap lasted more than one cycle");
    gap_off_a: assert property (@(posedge clock) disable iff (srst)
        (ce && !port.gap_en) |=> (gap_reg == '0))
        else $error("gap inserted while disabled");
    gap_seen_c: cover property (@(posedge clock) gap_reg != '0);
endmodule : tpg_pin_slice

// ### rtl/tpg_gpio.sv
// Top: three-port GPIO register set with break-before-make switching
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Control bit 3 reads zero, ignores writes
// - Control bit 2 gaps third port outputs
// - Control bit 1 gaps second port outputs
// - Control bit 0 gaps first port outputs
module tpg_gpio
    import tpg_pkg::*;
(
    // Clock, reset and clock enable
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    // Register bus, read data one cycle after the strobe
    input wire logic [TPG_ADDR_W-1:0] addr,
    input wire logic [TPG_DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [TPG_DATA_W-1:0] rdata,
    // First port pads
    input wire logic [TPG_PA_W-1:0] pa_in,
    output logic [TPG_PA_W-1:0] pa_out,
    output logic [TPG_PA_W-1:0] pa_oe_n,
    output logic [TPG_PA_W-1:0] pa_pue,
    // Second port pads
    input wire logic [TPG_PB_W-1:0] pb_in,
    output logic [TPG_PB_W-1:0] pb_out,
    output logic [TPG_PB_W-1:0] pb_oe_n,
    output logic [TPG_PB_W-1:0] pb_pue,
    // Third port pads
    input wire logic [TPG_PC_W-1:0] pc_in,
    output logic [TPG_PC_W-1:0] pc_out,
    output logic [TPG_PC_W-1:0] pc_oe_n,
    output logic [TPG_PC_W-1:0] pc_pue,
    // Stored analog-input disable bits, no effect inside
    output logic [3:0] analog_in_disable
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers
    // All state is plain flops; nothing here is a memory array.
    // Every flop honours the clock enable, so a low enable freezes the
    // whole block, bus writes included. Reset wins over the enable.
    // Narrow ports keep only their real bits; upper bits read as zero.
    // Input flops sample the pads once: pins are taken as synchronous.
    // Asynchronous pads need a synchroniser ahead of this block.
    logic [TPG_PA_W-1:0] a_dir_reg; // First port direction, 1 = output
    logic [TPG_PA_W-1:0] a_out_reg; // First port output latch
    logic [TPG_PA_W-1:0] a_pue_reg; // First port pull-up enables
    logic [TPG_PA_W-1:0] a_in_reg; // First port sampled pin levels

    logic [TPG_PB_W-1:0] b_dir_reg; // Second port direction
    logic [TPG_PB_W-1:0] b_out_reg; // Second port output latch
    logic [TPG_PB_W-1:0] b_pue_reg; // Second port pull-up enables
    logic [TPG_PB_W-1:0] b_in_reg; // Second port sampled pin levels

    logic [TPG_PC_W-1:0] c_dir_reg; // Third port direction
    logic [TPG_PC_W-1:0] c_out_reg; // Third port output latch
    logic [TPG_PC_W-1:0] c_pue_reg; // Third port pull-up enables
    logic [TPG_PC_W-1:0] c_in_reg; // Third port sampled pin levels

    logic [7:0] ctrl_reg; // Control register, bit 3 stuck at zero
    logic [7:0] rdata_next; // Read mux output
    // Write decode
    // A strobe counts only while the enable is high, so a frozen
    // block ignores the bus rather than storing a late write.
    // Unmapped offsets match none of these enables.
    wire we_a_dir = ce && wr && addr == TPG_OFS_A_DIR;
    wire we_a_out = ce && wr && addr == TPG_OFS_A_OUT;
    wire we_a_pue = ce && wr && addr == TPG_OFS_A_PUE;
    wire we_a_tgl = ce && wr && addr == TPG_OFS_A_IN;
    wire we_b_dir = ce && wr && addr == TPG_OFS_B_DIR;
    wire we_b_out = ce && wr && addr == TPG_OFS_B_OUT;
    wire we_b_pue = ce && wr && addr == TPG_OFS_B_PUE;
    wire we_b_tgl = ce && wr && addr == TPG_OFS_B_IN;
    wire we_c_dir = ce && wr && addr == TPG_OFS_C_DIR;
    wire we_c_out = ce && wr && addr == TPG_OFS_C_OUT;
    wire we_c_pue = ce && wr && addr == TPG_OFS_C_PUE;
    wire we_c_tgl = ce && wr && addr == TPG_OFS_C_IN;
    wire we_ctrl = ce && wr && addr == TPG_OFS_CTRL;
    // Writing ones to an input register toggles the output latch
    wire [TPG_PA_W-1:0] a_out_next = we_a_out ? wdata[TPG_PA_W-1:0]
        : we_a_tgl ? a_out_reg ^ wdata[TPG_PA_W-1:0] : a_out_reg;
    wire [TPG_PB_W-1:0] b_out_next = we_b_out ? wdata[TPG_PB_W-1:0]
        : we_b_tgl ? b_out_reg ^ wdata[TPG_PB_W-1:0] : b_out_reg;
    wire [TPG_PC_W-1:0] c_out_next = we_c_out ? wdata[TPG_PC_W-1:0]
        : we_c_tgl ? c_out_reg ^ wdata[TPG_PC_W-1:0] : c_out_reg;
    wire [7:0] ctrl_next = we_ctrl ? (wdata & TPG_CTRL_WMASK) : ctrl_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Storage per port
    // Direction and pull-up load only on their own strobe.
    // The latch next value already folds in the toggle path.
    // The input flop samples every enabled cycle, so reads of the
    // input register see the pad level one cycle late.
    // Port A storage
    always_ff @(posedge clock) begin
        if (srst) begin
            a_dir_reg <= TPG_RST_VAL[TPG_PA_W-1:0];
            a_out_reg <= TPG_RST_VAL[TPG_PA_W-1:0];
            a_pue_reg <= TPG_RST_VAL[TPG_PA_W-1:0];
            a_in_reg <= TPG_RST_VAL[TPG_PA_W-1:0];
        end else if (ce) begin
            if (we_a_dir) a_dir_reg <= wdata[TPG_PA_W-1:0];
            if (we_a_pue) a_pue_reg <= wdata[TPG_PA_W-1:0];
            a_out_reg <= a_out_next;
            a_in_reg <= pa_in;  // Pin level sampled every enabled cycle
        end
    end
    // Port B storage
    always_ff @(posedge clock) begin
        if (srst) begin
            b_dir_reg <= TPG_RST_VAL[TPG_PB_W-1:0];
            b_out_reg <= TPG_RST_VAL[TPG_PB_W-1:0];
            b_pue_reg <= TPG_RST_VAL[TPG_PB_W-1:0];
            b_in_reg <= TPG_RST_VAL[TPG_PB_W-1:0];
        end else if (ce) begin
            if (we_b_dir) b_dir_reg <= wdata[TPG_PB_W-1:0];
            if (we_b_pue) b_pue_reg <= wdata[TPG_PB_W-1:0];
            b_out_reg <= b_out_next;
            b_in_reg <= pb_in;
        end
    end
    // Port C storage
    always_ff @(posedge clock) begin
        if (srst) begin
            c_dir_reg <= TPG_RST_VAL[TPG_PC_W-1:0];
            c_out_reg <= TPG_RST_VAL[TPG_PC_W-1:0];
            c_pue_reg <= TPG_RST_VAL[TPG_PC_W-1:0];
            c_in_reg <= TPG_RST_VAL[TPG_PC_W-1:0];
        end else if (ce) begin
            if (we_c_dir) c_dir_reg <= wdata[TPG_PC_W-1:0];
            if (we_c_pue) c_pue_reg <= wdata[TPG_PC_W-1:0];
            c_out_reg <= c_out_next;
            c_in_reg <= pc_in;
        end
    end
    // Control register
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_reg <= TPG_RST_VAL;
        end else if (ce) begin
            ctrl_reg <= ctrl_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The mux is pure decode; the flop behind it gives the one-cycle
    // read latency the bus expects. Holding the output at zero outside
    // the answer cycle keeps stale data off the bus and makes a missed
    // strobe show up as zero rather than as an old value.
    // Read mux: narrow registers pad with zero, unmapped reads zero
    always_comb begin
        rdata_next = 8'h00;
        unique case (addr)
            TPG_OFS_A_IN: rdata_next = a_in_reg;
            TPG_OFS_A_DIR: rdata_next = a_dir_reg;
            TPG_OFS_A_OUT: rdata_next = a_out_reg;
            TPG_OFS_A_PUE: rdata_next = a_pue_reg;
            TPG_OFS_B_IN: rdata_next = {4'h0, b_in_reg};
            TPG_OFS_B_DIR: rdata_next = {4'h0, b_dir_reg};
            TPG_OFS_B_OUT: rdata_next = {4'h0, b_out_reg};
            TPG_OFS_B_PUE: rdata_next = {4'h0, b_pue_reg};
            TPG_OFS_CTRL: rdata_next = ctrl_reg;
            TPG_OFS_C_IN: rdata_next = {2'h0, c_in_reg};
            TPG_OFS_C_DIR: rdata_next = {2'h0, c_dir_reg};
            TPG_OFS_C_OUT: rdata_next = {2'h0, c_out_reg};
            TPG_OFS_C_PUE: rdata_next = {2'h0, c_pue_reg};
            default: rdata_next = 8'h00;  // Unmapped offset
        endcase
    end
    // Read data registered, valid only the cycle after the strobe
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= rd ? rdata_next : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin slices, one per port
    // Each slice sees the raw write data and strobe so that it can
    // compare the new direction against the old one in the same cycle.
    // That costs a little fan-out on the write data but lets the gap
    // start together with the direction change, with no extra delay
    // for ports whose gap is disabled.
    // Output to input needs no gap: the driver simply turns off.
    tpg_port_if #(.W(TPG_PA_W)) pa_if ();
    tpg_port_if #(.W(TPG_PB_W)) pb_if ();
    tpg_port_if #(.W(TPG_PC_W)) pc_if ();
    assign pa_if.dir = a_dir_reg;
    assign pa_if.latch = a_out_reg;
    assign pa_if.pue = a_pue_reg;
    assign pa_if.gap_en = ctrl_reg[TPG_CTRL_GAP_A];
    assign pa_if.dir_wr = wdata[TPG_PA_W-1:0];
    assign pa_if.dir_we = we_a_dir;
    assign pb_if.dir = b_dir_reg;
    assign pb_if.latch = b_out_reg;
    assign pb_if.pue = b_pue_reg;
    assign pb_if.gap_en = ctrl_reg[TPG_CTRL_GAP_B];
    assign pb_if.dir_wr = wdata[TPG_PB_W-1:0];
    assign pb_if.dir_we = we_b_dir;
    assign pc_if.dir = c_dir_reg;
    assign pc_if.latch = c_out_reg;
    assign pc_if.pue = c_pue_reg;
    assign pc_if.gap_en = ctrl_reg[TPG_CTRL_GAP_C];
    assign pc_if.dir_wr = wdata[TPG_PC_W-1:0];
    assign pc_if.dir_we = we_c_dir;

    tpg_pin_slice #(.W(TPG_PA_W)) u_pa (.clock(clock), .srst(srst), .ce(ce), .port(pa_if));
    tpg_pin_slice #(.W(TPG_PB_W)) u_pb (.clock(clock), .srst(srst), .ce(ce), .port(pb_if));
    tpg_pin_slice #(.W(TPG_PC_W)) u_pc (.clock(clock), .srst(srst), .ce(ce), .port(pc_if));

    // Pin outputs: latch value, enable, pull-up only when an input
    assign pa_out = a_out_reg;
    assign pb_out = b_out_reg;
    assign pc_out = c_out_reg;
    assign pa_oe_n = pa_if.pin_oe_n;
    assign pb_oe_n = pb_if.pin_oe_n;
    assign pc_oe_n = pc_if.pin_oe_n;
    assign pa_pue = a_pue_reg & ~a_dir_reg;
    assign pb_pue = b_pue_reg & ~b_dir_reg;
    assign pc_pue = c_pue_reg & ~c_dir_reg;
    // Analog disable bits are only stored and exported
    assign analog_in_disable = ctrl_reg[7:4];

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    rsvd_zero_a: assert property (@(posedge clock) disable iff (srst)
        ctrl_reg[TPG_CTRL_RSVD] == 1'b0)
        else $error("reserved control bit set");
    c_gap_a: assert property (@(posedge clock) disable iff (srst)
        (ce && we_c_dir && ctrl_reg[TPG_CTRL_GAP_C] && (wdata[0] && !c_dir_reg[0]))
        |=> pc_oe_n[0] ##1 (ce -> !pc_oe_n[0] || !c_dir_reg[0] || we_c_dir))
        else $error("third port gap wrong");
    b_gap_a: assert property (@(posedge clock) disable iff (srst)
        (ce && we_b_dir && ctrl_reg[TPG_CTRL_GAP_B] && wdata[0] && !b_dir_reg[0])
        |=> pb_oe_n[0])
        else $error("second port gap missing");
    a_nogap_a: assert property (@(posedge clock) disable iff (srst)
        (ce && we_a_dir && !ctrl_reg[TPG_CTRL_GAP_A] && wdata[0])
        |=> !pa_oe_n[0])
        else $error("first port drove late without gap");
    a_gap_a: assert property (@(posedge clock) disable iff (srst)
        (ce && we_a_dir && ctrl_reg[TPG_CTRL_GAP_A] && wdata[0] && !a_dir_reg[0])
        |=> pa_oe_n[0])
        else $error("first port gap missing");
    rd_data_a: assert property (@(posedge clock) disable iff (srst)
        (ce && rd && addr == TPG_OFS_CTRL) |=> rdata == $past(ctrl_reg))
        else $error("control readback wrong");
    ctrl_wr_c: cover property (@(posedge clock) we_ctrl && wdata[TPG_CTRL_GAP_C]);
    b_gap_c: cover property (@(posedge clock) we_b_dir && ctrl_reg[TPG_CTRL_GAP_B]);
    tgl_c: cover property (@(posedge clock) we_a_tgl);

    // Bus side checks
    // These guard register storage, read timing, freeze behaviour and switch gap timing.
    // Pin side checks follow: input pins are never driven and
    // driven first-port pins never keep their pull-up.

    // Read data falls back to zero after the answer cycle
    rdata_idle_a: assert property (@(posedge clock) disable iff (srst)
        (ce && !rd) |=> rdata == 8'h00)
        else $error("read data stood too long");

    // Low enable freezes the control register
    freeze_ctrl_a: assert property (@(posedge clock) disable iff (srst)
        !ce |=> $stable(ctrl_reg))
        else $error("control changed while frozen");

    // Low enable freezes the output latch
    freeze_out_a: assert property (@(posedge clock) disable iff (srst)
        !ce |=> $stable(a_out_reg))
        else $error("latch changed while frozen");

    // Control write keeps the reserved bit clear
    ctrl_wr_a: assert property (@(posedge clock) disable iff (srst)
        (ce && we_ctrl) |=> ctrl_reg == ($past(wdata) & TPG_CTRL_WMASK))
        else $error("control write stored wrong bits");

    // Second port without gap drives at once
    b_nogap_a: assert property (@(posedge clock) disable iff (srst)
        (ce && we_b_dir && !ctrl_reg[TPG_CTRL_GAP_B] && wdata[0]) |=> !pb_oe_n[0])
        else $error("second port drove late without gap");

    // Third port without gap drives at once
    c_nogap_a: assert property (@(posedge clock) disable iff (srst)
        (ce && we_c_dir && !ctrl_reg[TPG_CTRL_GAP_C] && wdata[0]) |=> !pc_oe_n[0])
        else $error("third port drove late without gap");

    // Second port gap ends after one cycle
    b_gap_len_a: assert property (@(posedge clock) disable iff (srst)
        (ce && we_b_dir && ctrl_reg[TPG_CTRL_GAP_B] && wdata[3] && !b_dir_reg[3])
        ##1 (ce && !we_b_dir) |=> !pb_oe_n[3])
        else $error("second port gap too long");

    // Direction write lands
    a_dir_wr_a: assert property (@(posedge clock) disable iff (srst)
        (ce && we_a_dir) |=> a_dir_reg == $past(wdata))
        else $error("direction write lost");

    // Latch write lands on the pad output
    a_out_wr_a: assert property (@(posedge clock) disable iff (srst)
        (ce && we_a_out) |=> pa_out == $past(wdata))
        else $error("latch write lost");

    // Ones written to the input register toggle the latch
    a_tgl_a: assert property (@(posedge clock) disable iff (srst)
        (ce && we_a_tgl) |=> pa_out == ($past(a_out_reg) ^ $past(wdata)))
        else $error("first port toggle wrong");

    // Toggle on the narrow second port
    b_tgl_a: assert property (@(posedge clock) disable iff (srst)
        (ce && we_b_tgl)
        |=> {4'h0, pb_out} == ({4'h0, $past(b_out_reg)} ^ ($past(wdata) & 8'h0F)))
        else $error("second port toggle wrong");

    // Third port latch write keeps its six bits
    c_out_wr_a: assert property (@(posedge clock) disable iff (srst)
        (ce && we_c_out) |=> {2'h0, pc_out} == ($past(wdata) & 8'h3F))
        else $error("third port latch write lost");

    // Pad level sampled once per enabled cycle
    a_in_smp_a: assert property (@(posedge clock) disable iff (srst)
        ce |=> a_in_reg == $past(pa_in))
        else $error("pin level not sampled");

    // Input pins are never driven
    a_in_only_a: assert property (@(posedge clock) disable iff (srst)
        ((~pa_oe_n) & ~a_dir_reg) == '0)
        else $error("first port drove an input pin");

    // Second port input pins are never driven
    b_in_only_a: assert property (@(posedge clock) disable iff (srst)
        ((~pb_oe_n) & ~b_dir_reg) == '0)
        else $error("second port drove an input pin");

    // Third port input pins are never driven
    c_in_only_a: assert property (@(posedge clock) disable iff (srst)
        ((~pc_oe_n) & ~c_dir_reg) == '0)
        else $error("third port drove an input pin");

    // A driven pin keeps its pull-up off
    a_pue_drv_a: assert property (@(posedge clock) disable iff (srst)
        (pa_pue & ~pa_oe_n) == '0)
        else $error("pull-up on while driving");
endmodule : tpg_gpio

// ### verif/tpg_pad_model.sv
// Pad model: external pin levels seen by one port of the GPIO block
module tpg_pad_model #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe_n,
    input wire logic [W-1:0] pue,
    input wire logic [W-1:0] ext_val,
    input wire logic ext_en,
    output logic [W-1:0] level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] float_reg = '0; // Undriven level, wanders so no stale value passes
    // Floating pins flip every cycle
    always @(posedge clock) begin
        float_reg <= ~float_reg;
    end
    // Block driver wins, then external source, then pull-up, else floating
    always_comb begin
        for (int i = 0; i < W; i++) begin
            level[i] = !oe_n[i] ? out[i] : ext_en ? ext_val[i] : pue[i] ? 1'b1 : float_reg[i];
        end
    end
endmodule : tpg_pad_model

// ### verif/tpg_gpio_tb.sv
// Testbench: register access, pin behaviour and switch gaps of the GPIO block
module tpg_gpio_tb;
    import tpg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic srst = 1'b1; // Held for two cycles at start
    logic ce = 1'b1;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ext_en = 1'b1; // External source drives idle pins
    logic [7:0] ext_a = 8'h3C; // External levels per port
    logic [3:0] ext_b = 4'h5;
    logic [5:0] ext_c = 6'h2A;
    logic [7:0] rdata, pa_in, pa_out, pa_oe_n, pa_pue;
    logic [3:0] pb_in, pb_out, pb_oe_n, pb_pue, analog_in_disable;
    logic [5:0] pc_in, pc_out, pc_oe_n, pc_pue;
    int bad_count = 0;
    int checks = 0;
    logic [4:0] dir_ofs[3] = '{TPG_OFS_A_DIR, TPG_OFS_B_DIR, TPG_OFS_C_DIR};
    logic [7:0] full[3] = '{8'hFF, 8'h0F, 8'h3F}; // Disabled drivers per port
    logic [4:0] zero_ofs[10] = '{TPG_OFS_A_DIR, TPG_OFS_A_OUT, TPG_OFS_A_PUE, TPG_OFS_B_DIR,
        TPG_OFS_B_OUT, TPG_OFS_B_PUE, TPG_OFS_CTRL, TPG_OFS_C_DIR, TPG_OFS_C_OUT, TPG_OFS_C_PUE};
    ////////////////////////////////////////////////////////////////////////////
    // Clock and instances
    initial begin
        forever #5 clock = ~clock;
    end
    tpg_gpio i_tpg_gpio (.clock(clock), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
        .pa_pue(pa_pue), .pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_pue(pb_pue),
        .pc_in(pc_in), .pc_out(pc_out), .pc_oe_n(pc_oe_n), .pc_pue(pc_pue),
        .analog_in_disable(analog_in_disable));
    tpg_pad_model #(.W(8)) i_tpg_pad_model_a (.clock(clock), .out(pa_out), .oe_n(pa_oe_n),
        .pue(pa_pue), .ext_val(ext_a), .ext_en(ext_en), .level(pa_in));
    tpg_pad_model #(.W(4)) i_tpg_pad_model_b (.clock(clock), .out(pb_out), .oe_n(pb_oe_n),
        .pue(pb_pue), .ext_val(ext_b), .ext_en(ext_en), .level(pb_in));
    tpg_pad_model #(.W(6)) i_tpg_pad_model_c (.clock(clock), .out(pc_out), .oe_n(pc_oe_n),
        .pue(pc_pue), .ext_val(ext_c), .ext_en(ext_en), .level(pc_in));
    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    // Compare one byte-wide result
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One-cycle write, entered just after an edge
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    // One-cycle read, data looked at in the following cycle only
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk("rdata", exp, rdata);
    endtask : rd_chk
    // Driver enables of one port, zero-extended
    function automatic logic [7:0] oe_of(input int p);
        return (p == 0) ? pa_oe_n : (p == 1) ? 8'(pb_oe_n) : 8'(pc_oe_n);
    endfunction : oe_of
    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        foreach (zero_ofs[i]) rd_chk(zero_ofs[i], 8'h00); // Reset values
        chk("oe_a", 8'hFF, pa_oe_n); // Drivers off after reset
        $display("test reset done");
        wr_reg(TPG_OFS_CTRL, 8'hFF);
        rd_chk(TPG_OFS_CTRL, 8'hF7);
        @(posedge clock);
        #1;
        chk("rdata idle", 8'h00, rdata); // Read data stands one cycle only
        chk("analog", 8'h0F, 8'(analog_in_disable));
        wr_reg(TPG_OFS_CTRL, 8'h08);
        rd_chk(TPG_OFS_CTRL, 8'h00);
        $display("test control done");
        // Gap on, input to output: one extra cycle with driver off
        for (int p = 0; p < 3; p++) begin
            wr_reg(TPG_OFS_CTRL, 8'(1 << p));
            wr_reg(dir_ofs[p], 8'h01);
            #1;
            chk("oe gap", full[p], oe_of(p));
            @(posedge clock);
            #1;
            chk("oe after gap", full[p] & 8'hFE, oe_of(p));
            wr_reg(dir_ofs[p], 8'h00);
            #1;
            chk("oe back to input", full[p], oe_of(p));
            wr_reg(TPG_OFS_CTRL, 8'h00);
            wr_reg(dir_ofs[p], 8'h01);
            #1;
            chk("oe no gap", full[p] & 8'hFE, oe_of(p));
            wr_reg(dir_ofs[p], 8'h00);
        end
        $display("test switch gap done");
        ext_b <= 4'hA;
        ext_c <= 6'h15;
        @(posedge clock);
        rd_chk(TPG_OFS_B_IN, 8'h0A); // Second port pins from external source
        rd_chk(TPG_OFS_C_IN, 8'h15); // Third port pins from external source
        wr_reg(TPG_OFS_B_DIR, 8'hFF);
        rd_chk(TPG_OFS_B_DIR, 8'h0F); // Upper bits absent
        wr_reg(TPG_OFS_C_PUE, 8'hFF);
        rd_chk(TPG_OFS_C_PUE, 8'h3F);
        chk("pue_c", 8'h3F, 8'(pc_pue));
        wr_reg(TPG_OFS_B_OUT, 8'h09);
        wr_reg(TPG_OFS_C_IN, 8'h3F); // Ones toggle the latch
        wr_reg(TPG_OFS_B_PUE, 8'hFF);
        chk("out_b", 8'h09, 8'(pb_out));
        chk("out_c", 8'h3F, 8'(pc_out));
        chk("pue_b", 8'h00, 8'(pb_pue)); // Outputs keep pull-ups off
        wr_reg(TPG_OFS_A_OUT, 8'hA5);
        #1;
        chk("out_a", 8'hA5, pa_out);
        wr_reg(TPG_OFS_A_IN, 8'h0F); // Ones toggle the latch
        rd_chk(TPG_OFS_A_OUT, 8'hAA);
        rd_chk(TPG_OFS_A_IN, 8'h3C); // Pins from external source
        wr_reg(TPG_OFS_A_DIR, 8'hF0);
        ext_en <= 1'b0;
        wr_reg(TPG_OFS_A_PUE, 8'hFF);
        #1;
        chk("pue_a", 8'h0F, pa_pue); // Pull-up only on inputs
        @(posedge clock);
        rd_chk(TPG_OFS_A_IN, 8'hAF); // Driven high nibble, pulled-up low nibble
        $display("test pins done");
        wr_reg(5'h10, 8'hFF);
        rd_chk(5'h10, 8'h00); // Unmapped place
        ce <= 1'b0;
        wr_reg(TPG_OFS_A_OUT, 8'h00); // Ignored while frozen
        ce <= 1'b1;
        rd_chk(TPG_OFS_A_OUT, 8'hAA);
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
        rd_chk(TPG_OFS_A_OUT, 8'h00); // Second reset clears state
        $display("test access done");
        report_and_stop();
    end
endmodule : tpg_gpio_tb
